// ### rtl/sfp_defines.vh
// Constants for the serial flash protect, power and hold control block.
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH
`define SFP_OP_WRITE_UNLOCK 8'h06
`define SFP_OP_WRITE_LOCK 8'h04
`define SFP_OP_STATUS_READ 8'h05
`define SFP_OP_STATUS_WRITE 8'h01
`define SFP_OP_PAGE_WRITE 8'h02
`define SFP_OP_SECTOR_CLEAR 8'hd8
`define SFP_OP_CHIP_CLEAR 8'hc7
`define SFP_OP_DEEP_SLEEP 8'hb9
`define SFP_OP_WAKE 8'hab
`define SFP_BIT_BUSY 0
`define SFP_BIT_LATCH 1
`define SFP_BIT_PROT_LO 2
`define SFP_BIT_PROT_HI 3
`define SFP_BIT_LOCK 7
`define SFP_PAGE_BYTES 256
`define SFP_TOP_SPLIT_BASE 24'h030000
`define SFP_MID_SPLIT_BASE 24'h010000
`define SFP_BOT_SPLIT_BASE 24'h000000
`define SFP_STATUS_WRITE_CYCLES 16'd100
`define SFP_PAGE_WRITE_CYCLES 16'd400
`define SFP_SECTOR_CLEAR_CYCLES 16'd1000
`define SFP_CHIP_CLEAR_CYCLES 16'd4000
`define SFP_POWER_UP_CYCLES 16'd200
`endif

// ### rtl/sfp_sync.v
// Two-flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/100ps
`default_nettype none
module sfp_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Pin side
  input wire [WIDTH-1:0] pin_in,
  // Logic side
  output reg [WIDTH-1:0] pin_out
);
  reg [WIDTH-1:0] stage1;

  always @(posedge clock)
  begin
    if (rst)
    begin
      stage1 <= {WIDTH{1'b1}};
      pin_out <= {WIDTH{1'b1}};
    end
    else
    begin
      stage1 <= pin_in;
      pin_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ### rtl/sfp_ctrl.v
// Serial flash control side: power states, status flags, protection and hold.
//
// Contract
// - Select low keeps device active.
// - Deselect waits for busy cycle, then standby.
// - Deep sleep command enters sleep until wake.
// - In sleep, only wake is obeyed; here a status read is still answered on the output line.
// - Busy flag tracks status write, program, erase.
// - Block-protect bits nonvolatile, select protected area; here reset clears them and any set bit protects the whole array.
// - Lock flag plus protect pin: hard lock.
// - Modifying command needs clock count multiple eight.
// - Latch clears at power-up and write completions.
// - Protect bits 00 none, 11 whole array.
// - Chip clear only with both protect bits zero.
// - Hold pauses link, internal cycle continues.
// - Hold starts when serial clock low.
// - Hold ends when serial clock low.
// - Hold: output floats, inputs ignored, state kept.
// - Deselect during hold resets serial logic.
// - Pages programmed; erase per sector or chip.
// - Top boot split region at upper block.
// - Bottom split at zero; middle top at 10000h.
// - Power-up timer blocks modifying commands.
// - Write unlock command 06h sets latch.
// - Select must rise on byte boundary.
// - Shift MSB first, sample on rising clock.
// - Array access ignored while cycle runs.
`timescale 1ns/100ps
`default_nettype none
`include "sfp_defines.vh"
module sfp_ctrl #(
  parameter ADDR_WIDTH = 18,
  parameter TOP_BOOT = 1,
  parameter [15:0] POWER_UP_CYCLES = `SFP_POWER_UP_CYCLES
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Serial link pins
  input wire serial_clk,
  input wire device_pick_n,
  input wire in_line,
  input wire hold_n,
  input wire protect_pin_n,
  output reg out_line,
  output reg out_line_oe,
  // State outputs
  output reg active_power,
  output reg deep_sleep,
  output reg hard_lock_mode,
  output reg soft_protect_mode,
  output reg [7:0] flash_status_byte,
  // Accepted array operations
  output reg array_op_pulse,
  output reg [1:0] array_op_kind,
  output reg [ADDR_WIDTH-1:0] array_op_addr
);
  localparam [1:0] KIND_PAGE = 2'd0;
  localparam [1:0] KIND_SECTOR = 2'd1;
  localparam [1:0] KIND_CHIP = 2'd2;
  localparam [1:0] KIND_STATUS = 2'd3;

  //////////////////////////////////////////////////////////////////////////////
  wire [3:0] pins;
  reg sclk_prev;
  reg pick_prev;
  sfp_sync #(.WIDTH(4)) u_sync (
    .clock(clock),
    .rst(rst),
    .pin_in({serial_clk, device_pick_n, in_line, hold_n}),
    .pin_out(pins)
  );
  wire sclk = pins[3];
  wire pick_n = pins[2];
  wire din = pins[1];
  wire hold_pin_n = pins[0];
  reg wp_s1, wp_n;
  always @(posedge clock)
  begin
    if (rst)
    begin
      wp_s1 <= 1'b1;
      wp_n <= 1'b1;
    end
    else
    begin
      wp_s1 <= protect_pin_n;
      wp_n <= wp_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  reg held;
  reg busy;
  reg latch;
  reg prot_lo, prot_hi, lock_bit;
  reg [15:0] pu_count;
  reg [15:0] cyc_count;
  reg [1:0] cyc_kind;
  reg [7:0] pend_status;
  reg [ADDR_WIDTH-1:0] pend_addr;
  reg [5:0] bit_count;
  reg [7:0] shreg;
  reg [7:0] opcode;
  reg [23:0] addr_sh;
  reg [7:0] data_byte;
  reg [7:0] out_sh;
  reg frame_on;

  wire sclk_rise = sclk & ~sclk_prev & ~held;
  wire sclk_fall = ~sclk & sclk_prev & ~held;
  wire frame_end = pick_n & ~pick_prev;
  wire hard_lock = lock_bit & ~wp_n;
  wire power_ok = (pu_count == 16'd0);

  // Sector protection for the coarse two-bit scheme.
  function prot_hit;
    input p_hi;
    input p_lo;
    begin
      prot_hit = p_hi | p_lo;
    end
  endfunction

  // Base of the split boot region for this density and boot side.
  function [23:0] split_base;
    input integer aw;
    input integer top;
    begin
      if (top == 0)
        split_base = `SFP_BOT_SPLIT_BASE;
      else if (aw >= 18)
        split_base = `SFP_TOP_SPLIT_BASE;
      else if (aw == 17)
        split_base = `SFP_MID_SPLIT_BASE;
      else
        split_base = 24'h000000;
    end
  endfunction
  localparam [23:0] SPLIT_BASE = split_base(ADDR_WIDTH, TOP_BOOT);

  //////////////////////////////////////////////////////////////////////////////
  // Hold only engages while selected and only once the serial clock is low.
  always @(posedge clock)
  begin
    if (rst)
      held <= 1'b0;
    else if (pick_n)
      held <= 1'b0;
    else if (!sclk)
      held <= ~hold_pin_n;
  end

  //////////////////////////////////////////////////////////////////////////////
  wire [7:0] next_shreg = {shreg[6:0], din};
  wire byte_ok = (bit_count[2:0] == 3'd0) && (bit_count != 6'd0);
  wire may_modify = latch & ~busy & ~deep_sleep & power_ok;

  always @(posedge clock)
  begin
    if (rst)
    begin
      sclk_prev <= 1'b0;
      pick_prev <= 1'b1;
      bit_count <= 6'd0;
      shreg <= 8'h00;
      opcode <= 8'h00;
      addr_sh <= 24'h000000;
      data_byte <= 8'h00;
      frame_on <= 1'b0;
      out_sh <= 8'h00;
      out_line <= 1'b0;
      out_line_oe <= 1'b0;
      latch <= 1'b0;
      deep_sleep <= 1'b0;
      busy <= 1'b0;
      cyc_count <= 16'd0;
      cyc_kind <= KIND_PAGE;
      pend_status <= 8'h00;
      pend_addr <= {ADDR_WIDTH{1'b0}};
      prot_lo <= 1'b0;
      prot_hi <= 1'b0;
      lock_bit <= 1'b0;
      pu_count <= POWER_UP_CYCLES;
      array_op_pulse <= 1'b0;
      array_op_kind <= KIND_PAGE;
      array_op_addr <= {ADDR_WIDTH{1'b0}};
    end
    else
    begin
      sclk_prev <= held ? sclk_prev : sclk;
      pick_prev <= pick_n;
      array_op_pulse <= 1'b0;
      if (!power_ok)
        pu_count <= pu_count - 16'd1;
      // The internal cycle runs regardless of hold or select.
      if (busy)
      begin
        if (cyc_count == 16'd1)
        begin
          busy <= 1'b0;
          latch <= 1'b0;
          if (cyc_kind == KIND_STATUS)
          begin
            prot_lo <= pend_status[`SFP_BIT_PROT_LO];
            prot_hi <= pend_status[`SFP_BIT_PROT_HI];
            lock_bit <= pend_status[`SFP_BIT_LOCK];
          end
          else
          begin
            array_op_pulse <= 1'b1;
            array_op_kind <= cyc_kind;
            array_op_addr <= pend_addr;
          end
        end
        cyc_count <= cyc_count - 16'd1;
      end
      out_line_oe <= ~pick_n & ~held & frame_on & (opcode == `SFP_OP_STATUS_READ);
      if (pick_n)
      begin
        frame_on <= 1'b0;
        bit_count <= 6'd0;
      end
      if (!pick_n && pick_prev)
        frame_on <= 1'b1;
      if (sclk_rise && !pick_n)
      begin
        shreg <= next_shreg;
        // Past seven bytes only the position inside a byte matters, so long page frames stay judgeable.
        bit_count <= (bit_count[5:3] == 3'd7) ? {3'd7, bit_count[2:0] + 3'd1} : bit_count + 6'd1;
        if (bit_count == 6'd7)
          opcode <= next_shreg;
        else if (bit_count >= 6'd8 && bit_count < 6'd32)
          addr_sh <= {addr_sh[22:0], din};
        if (bit_count[2:0] == 3'd7 && bit_count > 6'd7)
          data_byte <= next_shreg;
      end
      if (sclk_fall && !pick_n && bit_count >= 6'd8)
      begin
        out_line <= (bit_count[2:0] == 3'd0) ? flash_status_byte[7] : out_sh[7];
        out_sh <= (bit_count[2:0] == 3'd0) ? {flash_status_byte[6:0], 1'b0} : {out_sh[6:0], 1'b0};
      end
      // Instructions are judged when select rises; a rise during hold only resets.
      if (frame_end && frame_on && byte_ok && !held)
      begin
        if (deep_sleep)
        begin
          if (opcode == `SFP_OP_WAKE)
            deep_sleep <= 1'b0;
        end
        else
        begin
          case (opcode)
            `SFP_OP_WRITE_UNLOCK:
              if (bit_count == 6'd8 && power_ok)
                latch <= 1'b1;
            `SFP_OP_WRITE_LOCK:
              if (bit_count == 6'd8)
                latch <= 1'b0;
            `SFP_OP_DEEP_SLEEP:
              if (bit_count == 6'd8 && !busy)
                deep_sleep <= 1'b1;
            `SFP_OP_STATUS_WRITE:
              if (bit_count == 6'd16 && may_modify && !hard_lock)
              begin
                latch <= 1'b0;
                busy <= 1'b1;
                cyc_kind <= KIND_STATUS;
                cyc_count <= `SFP_STATUS_WRITE_CYCLES;
                pend_status <= data_byte;
              end
            `SFP_OP_PAGE_WRITE:
              if (bit_count >= 6'd40 && may_modify && !prot_hit(prot_hi, prot_lo))
              begin
                latch <= 1'b0;
                busy <= 1'b1;
                cyc_kind <= KIND_PAGE;
                cyc_count <= `SFP_PAGE_WRITE_CYCLES;
                pend_addr <= addr_sh[ADDR_WIDTH-1:0];
              end
            `SFP_OP_SECTOR_CLEAR:
              if (bit_count == 6'd32 && may_modify && !prot_hit(prot_hi, prot_lo))
              begin
                latch <= 1'b0;
                busy <= 1'b1;
                cyc_kind <= KIND_SECTOR;
                cyc_count <= `SFP_SECTOR_CLEAR_CYCLES;
                pend_addr <= addr_sh[ADDR_WIDTH-1:0];
              end
            `SFP_OP_CHIP_CLEAR:
              if (bit_count == 6'd8 && may_modify && !prot_lo && !prot_hi)
              begin
                latch <= 1'b0;
                busy <= 1'b1;
                cyc_kind <= KIND_CHIP;
                cyc_count <= `SFP_CHIP_CLEAR_CYCLES;
                pend_addr <= SPLIT_BASE[ADDR_WIDTH-1:0];
              end
            default:
              latch <= latch;
          endcase
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clock)
  begin
    if (rst)
    begin
      active_power <= 1'b0;
      hard_lock_mode <= 1'b0;
      soft_protect_mode <= 1'b0;
      flash_status_byte <= 8'h00;
    end
    else
    begin
      active_power <= ~pick_n | busy;
      hard_lock_mode <= hard_lock;
      soft_protect_mode <= prot_hit(prot_hi, prot_lo);
      flash_status_byte <= {lock_bit, 3'b000, prot_hi, prot_lo, latch, busy};
    end
  end
endmodule
`default_nettype wire

// ### tb/sfp_ctrl_props.sv
// Concurrent checks on the flash control block's ports.
`timescale 1ns/100ps
`default_nettype none
module sfp_ctrl_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial link pins
  input wire logic serial_clk,
  input wire logic device_pick_n,
  input wire logic hold_n,
  input wire logic protect_pin_n,
  input wire logic out_line_oe,
  // State outputs
  input wire logic active_power,
  input wire logic deep_sleep,
  input wire logic hard_lock_mode,
  input wire logic [7:0] flash_status_byte,
  input wire logic array_op_pulse,
  input wire logic [1:0] array_op_kind
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // Pin inputs pass a two-stage synchroniser, so each wait below allows for it.
  sequence sel_held;
    !device_pick_n [*4];
  endsequence
  sequence hold_idle;
    (!hold_n && !serial_clk && !device_pick_n) [*6];
  endsequence
  sel_active_a: assert property (sel_held |-> active_power)
    else $error("selected but not active");
  busy_active_a: assert property (flash_status_byte[0] [*2] |-> active_power || $past(active_power))
    else $error("busy but not active");
  sleep_idle_a: assert property (deep_sleep |-> !flash_status_byte[0])
    else $error("busy in deep sleep");
  sleep_quiet_a: assert property (deep_sleep [*3] |-> $stable(flash_status_byte))
    else $error("status changed in deep sleep");
  op_busy_a: assert property (array_op_pulse |-> $past(flash_status_byte[0], 2))
    else $error("array operation without busy");
  no_lock_a: assert property (protect_pin_n [*5] |-> !hard_lock_mode)
    else $error("hard lock with pin high");
  lock_bit_a: assert property (hard_lock_mode |-> flash_status_byte[7])
    else $error("hard lock without lock bit");
  done_latch_a: assert property ($fell(flash_status_byte[0]) |-> !flash_status_byte[1])
    else $error("latch set after cycle");
  full_protect_a: assert property (array_op_pulse |-> flash_status_byte[3:2] != 2'h3)
    else $error("operation on protected array");
  chip_clear_a: assert property (array_op_pulse && array_op_kind == 2'h2 |-> flash_status_byte[3:2] == 2'h0)
    else $error("chip clear with protection");
  hold_float_a: assert property (hold_idle |-> !out_line_oe)
    else $error("output driven in hold");
  reserved_zero_a: assert property (flash_status_byte[6:4] == 3'h0)
    else $error("reserved status bits set");
endmodule
bind sfp_ctrl sfp_ctrl_props sfp_ctrl_props_inst (
  .clock(clock), .rst(rst), .serial_clk(serial_clk), .device_pick_n(device_pick_n), .hold_n(hold_n),
  .protect_pin_n(protect_pin_n), .out_line_oe(out_line_oe), .active_power(active_power),
  .deep_sleep(deep_sleep), .hard_lock_mode(hard_lock_mode), .flash_status_byte(flash_status_byte),
  .array_op_pulse(array_op_pulse), .array_op_kind(array_op_kind)
);
`default_nettype wire

// ### tb/sfp_host_model.sv
// Host serial master model for the flash control block.
`timescale 1ns/100ps
`default_nettype none
module sfp_host_model (
  // Clock
  input wire logic clock,
  // Serial link
  output var logic serial_clk,
  output var logic device_pick_n,
  output var logic in_line,
  output var logic hold_n,
  input wire logic out_line
);
  initial
  begin
    serial_clk = 1'b0;
    device_pick_n = 1'b1;
    in_line = 1'b0;
    hold_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Each serial phase spans four system clocks so the sampled pins never miss an edge.
  task automatic frame(input logic [39:0] d, input int n, input int h, input bit ab, output logic [7:0] q);
    int i;
    q = 8'h00;
    @(posedge clock);
    device_pick_n <= 1'b0;
    tick(4);
    for (i = n - 1; i >= 0; i--)
    begin
      if (i == h)
      begin
        hold_n <= 1'b0;
        tick(8);
        repeat (2)
        begin
          serial_clk <= 1'b1;
          in_line <= ~in_line;
          tick(4);
          serial_clk <= 1'b0;
          tick(4);
        end
        if (ab)
        begin
          device_pick_n <= 1'b1;
          tick(4);
          hold_n <= 1'b1;
          tick(8);
          return;
        end
        hold_n <= 1'b1;
        tick(4);
      end
      in_line <= d[i];
      tick(4);
      serial_clk <= 1'b1;
      q = {q[6:0], out_line};
      tick(4);
      serial_clk <= 1'b0;
    end
    tick(4);
    device_pick_n <= 1'b1;
    in_line <= ~in_line;
    tick(4);
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the flash protect, power and hold control block.
`timescale 1ns/100ps
`default_nettype none
`include "sfp_defines.vh"
module testbench;
  logic clock, rst, protect_pin_n, serial_clk, device_pick_n, in_line, hold_n, out_line, out_line_oe;
  logic active_power, deep_sleep, hard_lock_mode, soft_protect_mode, array_op_pulse;
  logic [7:0] flash_status_byte;
  logic [7:0] q;
  logic [1:0] array_op_kind;
  logic [1:0] op_kind;
  logic [17:0] array_op_addr;
  logic [17:0] op_addr;
  logic [17:0] a;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int pulses = 0;
  int base, k, j;
  sfp_ctrl sfp_ctrl_inst (
    .clock(clock), .rst(rst), .serial_clk(serial_clk), .device_pick_n(device_pick_n), .in_line(in_line),
    .hold_n(hold_n), .protect_pin_n(protect_pin_n), .out_line(out_line), .out_line_oe(out_line_oe),
    .active_power(active_power), .deep_sleep(deep_sleep), .hard_lock_mode(hard_lock_mode),
    .soft_protect_mode(soft_protect_mode), .flash_status_byte(flash_status_byte),
    .array_op_pulse(array_op_pulse), .array_op_kind(array_op_kind), .array_op_addr(array_op_addr)
  );
  sfp_host_model sfp_host_model_inst (
    .clock(clock), .serial_clk(serial_clk), .device_pick_n(device_pick_n), .in_line(in_line),
    .hold_n(hold_n), .out_line(out_line)
  );
  ////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (array_op_pulse === 1'b1)
    begin
      pulses++;
      op_kind = array_op_kind;
      op_addr = array_op_addr;
    end
    if (cyc == 30000)
    begin
      err_count++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d err_count %0d", checks, err_count);
    if (checks > 0 && err_count == 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Outputs are read at the falling edge, well clear of their updates.
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic cmd(input logic [39:0] d, input int n, input int h = -1, input bit ab = 1'b0);
    sfp_host_model_inst.frame(d, n, h, ab, q);
    settle(2);
  endtask
  task automatic wait_idle;
    for (k = 0; k < 5000 && flash_status_byte[0] !== 1'b0; k++)
      @(posedge clock);
    settle(4);
  endtask
  function automatic logic [17:0] exp_addr(input int kind, input logic [17:0] x);
    logic [23:0] b;
    b = `SFP_TOP_SPLIT_BASE;
    return (kind == 2) ? b[17:0] : x;
  endfunction
  initial
  begin
    rst = 1'b1;
    protect_pin_n = 1'b1;
    void'($urandom(53888));
    settle(16);
    check("status", 8'h00, flash_status_byte);
    @(posedge clock);
    rst <= 1'b0;
    settle(3);
    cmd(8'h06, 8);
    check("latch", 1'b0, flash_status_byte[1]);
    settle(200);
    cmd(8'h06, 8);
    check("latch", 1'b1, flash_status_byte[1]);
    cmd(8'h04, 8);
    check("latch", 1'b0, flash_status_byte[1]);
    cmd(9'h00c, 9);
    check("latch", 1'b0, flash_status_byte[1]);
    cmd(8'h06, 8);
    cmd(16'h010c, 16);
    check("busy", 1'b1, flash_status_byte[0]);
    wait_idle;
    check("status", 8'h0c, flash_status_byte);
    check("soft", 1'b1, soft_protect_mode);
    for (j = 0; j < 2; j++)
    begin
      cmd(8'h06, 8);
      cmd(j ? 40'hc7 : 40'hd8000000, j ? 8 : 32);
      check("busy", 1'b0, flash_status_byte[0]);
    end
    cmd(8'h06, 8);
    cmd(16'h018c, 16);
    wait_idle;
    @(posedge clock);
    protect_pin_n <= 1'b0;
    settle(6);
    check("hard", 1'b1, hard_lock_mode);
    cmd(8'h06, 8);
    cmd(16'h0100, 16);
    wait_idle;
    check("status", 8'h8c, flash_status_byte & 8'hfd);
    @(posedge clock);
    protect_pin_n <= 1'b1;
    settle(6);
    cmd(8'h06, 8);
    cmd(16'h0100, 16);
    wait_idle;
    check("status", 8'h00, flash_status_byte);
    for (j = 0; j < 3; j++)
    begin
      a = j ? {2'($urandom_range(2)), 16'h0000} : {10'($urandom), 8'h00};
      base = pulses;
      cmd(8'h06, 8);
      if (j == 0)
        cmd({8'h02, 6'h00, a, 8'($urandom)}, 40);
      else
        cmd(j == 1 ? {8'hd8, 6'h00, a} : 40'hc7, j == 1 ? 32 : 8);
      check("busy", 1'b1, flash_status_byte[0]);
      if (j > 0)
      begin
        cmd(8'h06, 8);
        cmd(32'hd8000000, 32);
        sfp_host_model_inst.frame(16'h0500, 16, 5, 1'b0, q);
        check("read", 8'h01, q & 8'hfd);
      end
      wait_idle;
      check("pulses", 1, pulses - base);
      check("kind", j, op_kind);
      check("addr", exp_addr(j, a), op_addr);
      check("latch", 1'b0, flash_status_byte[1]);
    end
    cmd(8'hb9, 8);
    check("sleep", 1'b1, deep_sleep);
    cmd(8'h06, 8);
    check("latch", 1'b0, flash_status_byte[1]);
    cmd(8'hab, 8);
    check("sleep", 1'b0, deep_sleep);
    cmd(9'h00c, 9, 0, 1'b1);
    check("latch", 1'b0, flash_status_byte[1]);
    cmd(8'h06, 8, 3);
    check("latch", 1'b1, flash_status_byte[1]);
    final_report;
  end
endmodule
`default_nettype wire
